// File: bench/pks_asserts.sv
// pks_asserts: timing checks on the key, reset and status lines
// assumes short sim counts: on 20, off 30, boot 8, halt 8, reset 10
`timescale 1ns/100ps
module pks_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // link
    input wire logic power_key_n,
    input wire logic power_key_n_oe,
    input wire logic ext_reset_n,
    input wire logic status
);
    logic [7:0] key_low_q;
    logic [7:0] run_low_q;
    logic [7:0] rst_low_q;

    // saturating, so a tied-low key cannot wrap back to a short count
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            key_low_q <= 8'h0;
            run_low_q <= 8'h0;
            rst_low_q <= 8'h0;
        end else begin
            key_low_q <= power_key_n ? 8'h0 : key_low_q + {7'h0, ~&key_low_q};
            run_low_q <= (power_key_n || !status) ? 8'h0 : run_low_q + {7'h0, ~&run_low_q};
            rst_low_q <= ext_reset_n ? 8'h0 : rst_low_q + {7'h0, ~&rst_low_q};
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_drop;
        ##[1:4] !status;
    endsequence
    sequence s_boot;
        ##[6:12] status;
    endsequence

    AST_ON_HOLD: assert property ($rose(status) && !power_key_n |-> key_low_q >= 8'h1c)
        else $error("status rose before the key hold time");
    AST_ON_BOUND: assert property (!status && key_low_q == 8'h1a |-> ##[0:12] status)
        else $error("status late after a long key press");
    AST_HOLD_KEY: assert property (power_key_n_oe && !status |=> power_key_n_oe)
        else $error("key released before status high");
    AST_RUN_KEY: assert property (status && !power_key_n && ext_reset_n |=> status)
        else $error("status dropped while key still held");
    AST_OFF_SEQ: assert property ($rose(power_key_n) && $past(run_low_q) >= 8'h1e |-> ##[1:16] !status)
        else $error("no power-off after a long press");
    AST_OFF_LEN: assert property ($rose(power_key_n) && $past(run_low_q) > 8'h0a |-> $past(run_low_q) >= 8'h1e)
        else $error("off press released too early");
    AST_RST_SEQ: assert property ($rose(ext_reset_n) && status |-> s_drop ##0 s_boot)
        else $error("reset pulse did not restart the module");
    AST_RST_LEN: assert property ($rose(ext_reset_n) |-> $past(rst_low_q) >= 8'h0a)
        else $error("reset pulse too short");
endmodule

// File: bench/test_power_key_sequencer.sv
// test_power_key_sequencer: host and device joined, plus a bench-driven device
// assumes short sim counts; inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module test_power_key_sequencer;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic supply_ok = 1'h0;
    logic req_on = 1'h0;
    logic req_off = 1'h0;
    logic req_reset = 1'h0;
    logic cmd = 1'h0;
    logic cmd_b = 1'h0;
    logic busy, module_on, core_enable, core_reset, en_b, rst_b;
    int mismatches = 0;
    int n_checks = 0;
    int rst_cnt = 0;
    int rst_cnt_b = 0;
    // short sim counts shared by both device ends and the host
    localparam int unsigned T_ON = 20;
    localparam int unsigned T_OFF = 30;
    localparam int unsigned T_RST = 10;
    localparam int unsigned T_SEQ = 8;
    localparam int unsigned T_SETTLE = 5;
    // host holds a little past the device minimum for margin
    localparam int unsigned T_HOST_OFF = T_OFF + 5;
    localparam int unsigned T_HOST_RST = T_RST + 2;
    pks_if lnk();
    pks_if lnk_b();
    pks_device #(.ON_HOLD(T_ON), .OFF_HOLD(T_OFF), .RST_MIN(T_RST),
        .BOOT(T_SEQ), .HALT(T_SEQ)) pks_device_i (
        .mclk(mclk), .resetn(resetn), .lnk(lnk.dev), .shutdown_command(cmd),
        .core_enable(core_enable), .core_reset(core_reset));
    // second end: bench plays the host to break its rules on purpose
    pks_device #(.ON_HOLD(T_ON), .OFF_HOLD(T_OFF), .RST_MIN(T_RST),
        .BOOT(T_SEQ), .HALT(T_SEQ)) pks_device_b_i (
        .mclk(mclk), .resetn(resetn), .lnk(lnk_b.dev), .shutdown_command(cmd_b),
        .core_enable(en_b), .core_reset(rst_b));
    pks_host #(.SETTLE(T_SETTLE), .OFF_HOLD(T_HOST_OFF), .RST_PULSE(T_HOST_RST)) pks_host_i (
        .mclk(mclk), .resetn(resetn), .lnk(lnk.host), .supply_ok(supply_ok), .req_on(req_on),
        .req_off(req_off), .req_reset(req_reset), .busy(busy), .module_on(module_on));
    pks_asserts pks_asserts_i (.mclk(mclk), .resetn(resetn), .power_key_n(lnk.power_key_n),
        .power_key_n_oe(lnk.power_key_n_oe), .ext_reset_n(lnk.ext_reset_n), .status(lnk.status));

    initial forever #10 mclk = ~mclk;

    always @(posedge mclk) begin
        rst_cnt <= rst_cnt + int'(core_reset);
        rst_cnt_b <= rst_cnt_b + int'(rst_b);
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wait_lvl(input bit on_b, input logic v);
        int n = 0;
        while ((on_b ? lnk_b.status : busy) !== v && n < 500) begin
            step(1);
            n++;
        end
        if (n >= 500) begin
            mismatches++;
            close_out();
        end
    endtask

    // one-cycle request pulse, then wait for the host to go idle
    task automatic host(input int which);
        req_on = (which == 0);
        req_off = (which == 1);
        req_reset = (which == 2);
        step(1);
        {req_on, req_off, req_reset} = 3'h0;
        step(1);
        wait_lvl(1'h0, 1'h0);
    endtask

    task automatic hold_b(input bit rst, input int n);
        if (rst) begin
            lnk_b.ext_reset_n_oe = 1'h1;
        end else begin
            lnk_b.power_key_n_oe = 1'h1;
        end
        step(n);
        lnk_b.ext_reset_n_oe = 1'h0;
        lnk_b.power_key_n_oe = 1'h0;
    endtask

    initial begin
        lnk_b.power_key_n_o = 1'h0;
        lnk_b.ext_reset_n_o = 1'h0;
        lnk_b.power_key_n_oe = 1'h0;
        lnk_b.ext_reset_n_oe = 1'h0;
        step(3);
        resetn = 1'h1;
        chk("status after reset", 1'h0, lnk.status);
        chk("enable after reset", 1'h0, core_enable);
        supply_ok = 1'h1;
        host(0);
        chk("key before settle", 1'h0, lnk.power_key_n_oe);
        step(6);
        host(0);
        chk("status on", 1'h1, lnk.status);
        chk("module on", 1'h1, module_on);
        chk("key released", 1'h0, lnk.power_key_n_oe);
        $display("test power on done");
        host(2);
        step(16);
        chk("reset pulse", 1'h1, rst_cnt == 1);
        chk("status after pulse", 1'h1, lnk.status);
        host(1);
        chk("status off", 1'h0, lnk.status);
        chk("enable off", 1'h0, core_enable);
        host(2);
        step(16);
        chk("reset in off", 1'h1, rst_cnt == 1);
        chk("stays off", 1'h0, lnk.status);
        host(0);
        cmd = 1'h1;
        step(1);
        cmd = 1'h0;
        step(20);
        chk("command off", 1'h0, lnk.status);
        chk("command enable", 1'h0, core_enable);
        $display("test host sequences done");
        hold_b(1'h0, 15);
        step(20);
        chk("short press", 1'h0, lnk_b.status);
        hold_b(1'h0, 100);
        step(20);
        chk("held key on", 1'h1, lnk_b.status);
        chk("held key enable", 1'h1, en_b);
        hold_b(1'h0, 20);
        step(20);
        chk("short press in run", 1'h1, lnk_b.status);
        hold_b(1'h1, 5);
        step(20);
        chk("short reset", 1'h1, rst_cnt_b == 0);
        lnk_b.power_key_n_oe = 1'h1;
        cmd_b = 1'h1;
        step(1);
        cmd_b = 1'h0;
        wait_lvl(1'h1, 1'h0);
        wait_lvl(1'h1, 1'h1);
        lnk_b.power_key_n_oe = 1'h0;
        step(30);
        cmd_b = 1'h1;
        step(1);
        cmd_b = 1'h0;
        step(60);
        chk("key high stays off", 1'h0, lnk_b.status);
        $display("test second end done");
        close_out();
    end
endmodule

// File: hw/pks_device.sv
// pks_device: module-side power sequencer timing key, command and reset
// assumes host keeps to supply settling and key release obligations
// Function
// - key low 500 ms powers on
// - host holds key until status high
// - host waits 30 ms after supply
// - key tied low auto powers on
// - key 650 ms, off after release
// - command shutdown same orderly sequence
// - key low after command shutdown restarts
// - supply cut only after shutdown
// - reset pulse 150..460 ms resets module
// - reset line only as fallback
// - both shutdowns reach same off state
// - powered down: software and serial inactive
`timescale 1ns/100ps
module pks_device #(
    parameter int unsigned ON_HOLD = pks_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = pks_pkg::OFF_HOLD_CYC,
    parameter int unsigned RST_MIN = pks_pkg::RST_MIN_CYC,
    parameter int unsigned BOOT = pks_pkg::BOOT_CYC,
    parameter int unsigned HALT = pks_pkg::HALT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // link
    pks_if.dev lnk,
    // module core side
    input wire logic shutdown_command,
    output logic core_enable,
    output logic core_reset
);
    import pks_pkg::*;

    // a zero count would make a sequence step vanish
    if (ON_HOLD == 0 || OFF_HOLD == 0 || RST_MIN == 0) begin
        $error("pks_device: zero hold or reset time");
    end
    if (BOOT == 0 || HALT == 0) begin
        $error("pks_device: zero sequence length");
    end

    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_BOOT = 5'b00010,
        ST_RUN = 5'b00100,
        ST_WREL = 5'b01000,
        ST_HALT = 5'b10000
    } pks_state_e;

    logic [1:0] key_sync_q, key_sync_d;
    logic [1:0] rst_sync_q, rst_sync_d;
    logic [CNT_W-1:0] key_cnt_q, key_cnt_d;
    logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic [CNT_W-1:0] seq_cnt_q, seq_cnt_d;
    pks_state_e state_q, state_d;
    logic status_q, status_d;
    logic core_rst_q, core_rst_d;
    logic key_free_q, key_free_d;
    logic key_low, rst_low, rst_fire, off_press;

    // pins pass two flops before use
    always_comb begin
        key_sync_d = {key_sync_q[0], lnk.power_key_n};
        rst_sync_d = {rst_sync_q[0], lnk.ext_reset_n};
    end

    // idle level is high, so no false press follows reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            key_sync_q <= 2'h3;
            rst_sync_q <= 2'h3;
        end else begin
            key_sync_q <= key_sync_d;
            rst_sync_q <= rst_sync_d;
        end
    end
    assign key_low = !key_sync_q[1];
    assign rst_low = !rst_sync_q[1];

    always_comb begin
        key_cnt_d = '0;
        if (key_low) begin
            key_cnt_d = (key_cnt_q == '1) ? key_cnt_q : key_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            key_cnt_q <= '0;
        end else begin
            key_cnt_q <= key_cnt_d;
        end
    end

    always_comb begin
        rst_cnt_d = '0;
        if (rst_low) begin
            rst_cnt_d = (rst_cnt_q == '1) ? rst_cnt_q : rst_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rst_cnt_q <= '0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
        end
    end
    // accept qualified reset pulse
    // longer pulses still reset; upper bound is the host's to keep
    assign rst_fire = !rst_low && (rst_cnt_q >= CNT_W'(RST_MIN));

    // key must be seen high in run before an off press counts
    // a key held through boot, or tied low, never arms the halt
    always_comb begin
        key_free_d = 1'b0;
        if (state_q == ST_RUN || state_q == ST_WREL) begin
            key_free_d = key_free_q || !key_low;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            key_free_q <= 1'b0;
        end else begin
            key_free_q <= key_free_d;
        end
    end

    assign off_press = key_free_q && (key_cnt_q >= CNT_W'(OFF_HOLD));

    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q + 1'b1;
        status_d = status_q;
        core_rst_d = 1'b0;
        unique case (state_q)
            ST_OFF: begin
                seq_cnt_d = '0;
                if (key_cnt_q >= CNT_W'(ON_HOLD))
                    state_d = ST_BOOT;
            end
            ST_BOOT: begin
                if (seq_cnt_q >= CNT_W'(BOOT - 1)) begin
                    status_d = 1'b1;
                    state_d = ST_RUN;
                    seq_cnt_d = '0;
                end
            end
            ST_RUN: begin
                seq_cnt_d = '0;
                if (shutdown_command)
                    state_d = ST_HALT;
                else if (off_press)
                    state_d = ST_WREL;
            end
            ST_WREL: begin
                seq_cnt_d = '0;
                if (!key_low)
                    state_d = ST_HALT;
            end
            ST_HALT: begin
                if (seq_cnt_q >= CNT_W'(HALT - 1)) begin
                    status_d = 1'b0;
                    state_d = ST_OFF;
                    seq_cnt_d = '0;
                end
            end
        endcase
        if (rst_fire && state_q != ST_OFF) begin
            core_rst_d = 1'b1;
            status_d = 1'b0;
            state_d = ST_BOOT;
            seq_cnt_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q <= ST_OFF;
            seq_cnt_q <= '0;
            status_q <= 1'b0;
            core_rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
            status_q <= status_d;
            core_rst_q <= core_rst_d;
        end
    end

    assign lnk.status = status_q;
    assign core_enable = (state_q != ST_OFF);
    assign core_reset = core_rst_q;
endmodule

// File: hw/pks_host.sv
// pks_host: host-side controller driving power key and reset lines
// assumes supply_ok is from the host's own clock domain, already clean
`timescale 1ns/100ps
module pks_host #(
    parameter int unsigned SETTLE = pks_pkg::SUPPLY_SETTLE_CYC,
    parameter int unsigned OFF_HOLD = pks_pkg::OFF_HOLD_CYC,
    parameter int unsigned RST_PULSE = pks_pkg::RST_MIN_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // link
    pks_if.host lnk,
    // supply level, user requests as one-cycle pulses, busy and status outputs
    input wire logic supply_ok,
    input wire logic req_on,
    input wire logic req_off,
    input wire logic req_reset,
    output logic busy,
    output logic module_on
);
    import pks_pkg::*;

    // a zero count or an over-long pulse breaks the host's side of the timing
    if (SETTLE == 0 || OFF_HOLD == 0 || RST_PULSE == 0 || RST_PULSE > RST_MAX_CYC) begin
        $error("pks_host: bad time parameter");
    end

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_ON = 4'b0010,
        HS_OFF = 4'b0100,
        HS_RST = 4'b1000
    } pks_hstate_e;

    pks_hstate_e st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, settle_q, settle_d;
    logic [1:0] stat_sync_q;
    logic key_q, key_d, rst_q, rst_d;
    logic stat;

    always_ff @(posedge mclk) begin
        if (!resetn)
            stat_sync_q <= 2'h0;
        else
            stat_sync_q <= {stat_sync_q[0], lnk.status};
    end
    assign stat = stat_sync_q[1];

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 1'b1;
        key_d = 1'b0;
        rst_d = 1'b0;
        settle_d = !supply_ok ? '0 : (settle_q >= CNT_W'(SETTLE)) ? settle_q : settle_q + 1'b1;
        unique case (st_q)
            HS_IDLE: begin
                cnt_d = '0;
                if (settle_q >= CNT_W'(SETTLE)) begin
                    if (req_on && !stat)
                        st_d = HS_ON;
                    else if (req_off && stat)
                        st_d = HS_OFF;
                    else if (req_reset)
                        st_d = HS_RST;
                end
            end
            HS_ON: begin
                key_d = !stat;
                if (stat)
                    st_d = HS_IDLE;
            end
            HS_OFF: begin
                // hold OFF_HOLD cycles (650 ms by default) then release
                key_d = (cnt_q < CNT_W'(OFF_HOLD));
                if (!key_d && !stat)
                    st_d = HS_IDLE;
            end
            HS_RST: begin
                rst_d = (cnt_q < CNT_W'(RST_PULSE));
                if (!rst_d)
                    st_d = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q <= HS_IDLE;
            cnt_q <= '0;
            settle_q <= '0;
            key_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            settle_q <= settle_d;
            key_q <= key_d;
            rst_q <= rst_d;
        end
    end

    assign lnk.power_key_n_o = 1'b0;
    assign lnk.power_key_n_oe = key_q;
    assign lnk.ext_reset_n_o = 1'b0;
    assign lnk.ext_reset_n_oe = rst_q;
    assign busy = (st_q != HS_IDLE);
    assign module_on = stat;
endmodule

// File: shared/pks_if.sv
// pks_if: power key, reset and status lines between host and module
// open-drain lines resolve low when the host enables its driver
`timescale 1ns/100ps
interface pks_if;
    logic power_key_n_o;
    logic power_key_n_oe;
    logic ext_reset_n_o;
    logic ext_reset_n_oe;
    logic status;
    // wired levels, pulled up when released
    logic power_key_n;
    logic ext_reset_n;
    assign power_key_n = power_key_n_oe ? power_key_n_o : 1'b1;
    assign ext_reset_n = ext_reset_n_oe ? ext_reset_n_o : 1'b1;
    modport dev (input power_key_n, input ext_reset_n, output status);
    modport host (output power_key_n_o, output power_key_n_oe, output ext_reset_n_o,
        output ext_reset_n_oe, input status);
endinterface

// File: shared/pks_pkg.sv
// pks_pkg: constants shared by both ends of the power key sequencer link
// assumes a single 50 MHz clock on both ends
package pks_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // times in ms, as printed
    localparam int unsigned ON_HOLD_MS = 500;
    localparam int unsigned OFF_HOLD_MS = 650;
    localparam int unsigned SUPPLY_SETTLE_MS = 30;
    localparam int unsigned RST_MIN_MS = 150;
    localparam int unsigned RST_MAX_MS = 460;
    // derived cycle counts (exact, as 50 MHz gives a whole count per ms)
    localparam int unsigned ON_HOLD_CYC = ON_HOLD_MS * CYC_PER_MS;
    localparam int unsigned OFF_HOLD_CYC = OFF_HOLD_MS * CYC_PER_MS;
    localparam int unsigned SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_MS * CYC_PER_MS;
    localparam int unsigned RST_MIN_CYC = RST_MIN_MS * CYC_PER_MS;
    localparam int unsigned RST_MAX_CYC = RST_MAX_MS * CYC_PER_MS;
    // internal step lengths of the device sequences, plain defaults
    localparam int unsigned BOOT_CYC = 1000;
    localparam int unsigned HALT_CYC = 1000;
    localparam int unsigned CNT_W = 32;
endpackage
